// ===== common/slcd_pkg.sv
// Purpose: shared constants and types of the segment display driver
// Assumes: one 25 MHz clock, source ticks arrive from slow oscillators
// Notes:   level codes select one of four bias rails per pin
package slcd_pkg;

	// -------------------------------------------------------------
	// sizes
	// -------------------------------------------------------------
	localparam int NUM_PINS   = 40;
	localparam int NUM_SEG    = 36;
	localparam int NUM_COM    = 8;
	localparam int FIRST_DCOM = 36;
	localparam int SHARE_TOP  = 39;

	// -------------------------------------------------------------
	// codes
	// -------------------------------------------------------------
	localparam logic [1:0] LVL_GND  = 2'h0;
	localparam logic [1:0] LVL_V1   = 2'h1;
	localparam logic [1:0] LVL_V2   = 2'h2;
	localparam logic [1:0] LVL_VLCD = 2'h3;

	localparam logic [1:0] COMSEL_4 = 2'h0;
	localparam logic [1:0] COMSEL_6 = 2'h1;
	localparam logic [1:0] COMSEL_7 = 2'h2;
	localparam logic [1:0] COMSEL_8 = 2'h3;

	localparam logic [3:0] COMCNT_4 = 4'h4;
	localparam logic [3:0] COMCNT_6 = 4'h6;
	localparam logic [3:0] COMCNT_7 = 4'h7;
	localparam logic [3:0] COMCNT_8 = 4'h8;

	localparam logic [7:0] DIV_BASE = 8'h10;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef struct packed {
		logic        staticModeSelect;
		logic        frameClockSourceSelect;
		logic [1:0]  frameDividerSelect;
		logic [1:0]  commonCountSelect;
		logic [35:0] segmentPinEnable;
		logic        singleFrameSelect;
		logic        idleCommonDrive;
		logic        frameIrqEnable;
		logic        stopWakeEnable;
	} slcd_cfg_t;

	typedef struct packed {
		logic       pointerWrite;
		logic [5:0] bufferPointer;
		logic       dataWrite;
		logic [7:0] bufferDataPort;
	} slcd_bufwr_t;

	typedef struct packed {
		logic [39:0]      lcdOwned;
		logic [39:0]      biasSwitch;
		logic [39:0][1:0] level;
		logic [39:0]      outLatch;
	} slcd_pins_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'b01,
		ST_RUN = 2'b10
	} slcd_state_t;

endpackage : slcd_pkg

// ===== logic/slcd_driver.sv
// Purpose: segment display timing, waveform and pin ownership
// Assumes: oscillator ticks are asynchronous square waves
// Notes:   pins 0..35 are segment/shared pins, 36..39 dedicated commons
//
// Operation
// - static select clear gives 1/3 bias multiplex; set gives static drive.
// - source select picks the 16 kHz RC or the 32.768 kHz crystal.
// - divider codes 00..11 divide the source by 16, 32, 64, 128.
// - one frame lasts twice the common count in divided clock periods.
// - supports 36x4, 34x6, 33x7 and 32x8 segment by common layouts.
// - four shared pins governed by segment enables and common count.
// - static mode turns off every bias switch; pins drive ground or supply.
// - static mode writes selected pins' output latches directly.
// - frame-done flag is set at the end of every frame.
// - flag requests the interrupt only while frame interrupt enable is 1.
// - flag clears when the interrupt controller accepts the interrupt.
// - when enabled dedicated commons are commons; segment pins follow their bits.
// - shared pins claimed by the common count are commons regardless of bits.
// - display disabled with idle drive clear returns every pin to ordinary port control.
// - interrupt wakes from idle; stop-wake lets it run and wake in stop.
// - common count codes 00..11 select 4, 6, 7 or 8 commons.
// - single-frame mode outputs one frame then clears display enable.
// - idle drive with display off puts commons at V1, or supply if static.
// - 36 by 8 pixel buffer, pointer written first, then data port.
`timescale 1ns/1ps
module slcd_driver (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire slcd_pkg::slcd_cfg_t  cfg,
	input  wire logic                 enableWrite,
	input  wire logic                 enableValue,
	input  wire slcd_pkg::slcd_bufwr_t bufWrite,
	input  wire logic                 rcTick,
	input  wire logic                 xtalTick,
	input  wire logic                 irqAccept,
	input  wire logic                 inStop,
	output logic                      displayEnableBit,
	output logic                      frameDoneFlag,
	output logic                      irqRequest,
	output logic                      wakeRequest,
	output logic                      biasGenOn,
	output logic [7:0]                bufReadData,
	output slcd_pkg::slcd_pins_t      pins
);

	// -------------------------------------------------------------
	// decoding helpers
	// -------------------------------------------------------------
	function automatic logic [3:0] comCount(input logic [1:0] sel);
		case (sel)
			slcd_pkg::COMSEL_4: comCount = slcd_pkg::COMCNT_4;
			slcd_pkg::COMSEL_6: comCount = slcd_pkg::COMCNT_6;
			slcd_pkg::COMSEL_7: comCount = slcd_pkg::COMCNT_7;
			default:            comCount = slcd_pkg::COMCNT_8;
		endcase
	endfunction : comCount

	// shared pin 35 is common 4 down to pin 32 as common 7
	function automatic logic pinIsCom(input int p, input logic [1:0] sel);
		logic [3:0] n;
		n = comCount(sel);
		if (p >= slcd_pkg::FIRST_DCOM)
			pinIsCom = 1'b1;
		else if (p >= 32)
			pinIsCom = (4'(slcd_pkg::SHARE_TOP - p) < n);
		else
			pinIsCom = 1'b0;
	endfunction : pinIsCom

	function automatic logic [2:0] pinComIndex(input int p);
		if (p >= slcd_pkg::FIRST_DCOM)
			pinComIndex = 3'(p - slcd_pkg::FIRST_DCOM);
		else
			pinComIndex = 3'(slcd_pkg::SHARE_TOP - p);
	endfunction : pinComIndex

	// -------------------------------------------------------------
	// oscillator tick synchronisers
	// -------------------------------------------------------------
	logic [2:0] rcSync_q;
	logic [2:0] rcSync_d;
	logic [2:0] xtSync_q;
	logic [2:0] xtSync_d;
	logic       srcTick;

	always_comb
	begin
		rcSync_d = {rcSync_q[1:0], rcTick};
		xtSync_d = {xtSync_q[1:0], xtalTick};
		// third stage only serves the edge detector
		if (cfg.frameClockSourceSelect)
			srcTick = xtSync_q[1] & ~xtSync_q[2];
		else
			srcTick = rcSync_q[1] & ~rcSync_q[2];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rcSync_q <= 3'h0;
			xtSync_q <= 3'h0;
		end
		else
		begin
			rcSync_q <= rcSync_d;
			xtSync_q <= xtSync_d;
		end
	end

	// -------------------------------------------------------------
	// frame timing and enable control
	// -------------------------------------------------------------
	slcd_pkg::slcd_state_t state_q;
	slcd_pkg::slcd_state_t state_d;
	logic [7:0] preCnt_q;
	logic [7:0] preCnt_d;
	logic [3:0] phase_q;
	logic [3:0] phase_d;
	logic       enable_q;
	logic       enable_d;
	logic       flag_q;
	logic       flag_d;
	logic       frameEnd;
	logic       running;
	logic [7:0] divLast;
	logic [3:0] nCom;

	always_comb
	begin
		nCom = comCount(cfg.commonCountSelect);
		divLast = 8'((slcd_pkg::DIV_BASE << cfg.frameDividerSelect) - 8'h01);
		// stop mode freezes the driver unless stop-wake is set
		running = (~inStop) | cfg.stopWakeEnable;
		state_d = state_q;
		preCnt_d = preCnt_q;
		phase_d = phase_q;
		frameEnd = 1'b0;
		enable_d = enable_q;
		case (state_q)
			slcd_pkg::ST_OFF:
			begin
				preCnt_d = slcd_pkg::RESET_BYTE;
				phase_d = 4'h0;
				if (enable_q)
					state_d = slcd_pkg::ST_RUN;
			end
			slcd_pkg::ST_RUN:
			begin
				if (!enable_q)
					state_d = slcd_pkg::ST_OFF;
				else if (srcTick && running)
				begin
					if (preCnt_q >= divLast)
					begin
						preCnt_d = slcd_pkg::RESET_BYTE;
						if (phase_q >= 4'((nCom << 1) - 4'h1))
						begin
							phase_d = 4'h0;
							frameEnd = 1'b1;
						end
						else
							phase_d = phase_q + 4'h1;
					end
					else
						preCnt_d = preCnt_q + 8'h01;
				end
			end
			default:
				state_d = slcd_pkg::ST_OFF;
		endcase
		if (frameEnd && cfg.singleFrameSelect)
			enable_d = 1'b0;
		if (enableWrite)
			enable_d = enableValue;
		// a new frame end beats a simultaneous accept
		flag_d = flag_q;
		if (irqAccept)
			flag_d = 1'b0;
		if (frameEnd)
			flag_d = 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= slcd_pkg::ST_OFF;
			preCnt_q <= slcd_pkg::RESET_BYTE;
			phase_q <= 4'h0;
			enable_q <= 1'b0;
			flag_q <= 1'b0;
			irqRequest <= 1'b0;
			wakeRequest <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			preCnt_q <= preCnt_d;
			phase_q <= phase_d;
			enable_q <= enable_d;
			flag_q <= flag_d;
			irqRequest <= flag_d & cfg.frameIrqEnable;
			wakeRequest <= flag_d & cfg.frameIrqEnable & running;
		end
	end

	assign displayEnableBit = enable_q;
	assign frameDoneFlag = flag_q;

	// -------------------------------------------------------------
	// pixel buffer
	// -------------------------------------------------------------
	logic [7:0] pixMem_q [slcd_pkg::NUM_SEG];
	logic [7:0] pixMem_d [slcd_pkg::NUM_SEG];
	logic [5:0] ptr_q;
	logic [5:0] ptr_d;
	logic [7:0] rd_d;

	always_comb
	begin
		pixMem_d = pixMem_q;
		ptr_d = ptr_q;
		if (bufWrite.pointerWrite)
			ptr_d = bufWrite.bufferPointer;
		if (bufWrite.dataWrite && (ptr_q < 6'(slcd_pkg::NUM_SEG)))
			pixMem_d[ptr_q] = bufWrite.bufferDataPort;
		rd_d = (ptr_d < 6'(slcd_pkg::NUM_SEG)) ? pixMem_d[ptr_d] : slcd_pkg::RESET_BYTE;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			for (int i = 0; i < slcd_pkg::NUM_SEG; i++)
				pixMem_q[i] <= slcd_pkg::RESET_BYTE;
			ptr_q <= 6'h00;
			bufReadData <= slcd_pkg::RESET_BYTE;
		end
		else
		begin
			pixMem_q <= pixMem_d;
			ptr_q <= ptr_d;
			bufReadData <= rd_d;
		end
	end

	// -------------------------------------------------------------
	// pin ownership and waveform
	// -------------------------------------------------------------
	slcd_pkg::slcd_pins_t pins_d;
	logic [39:0] segEn;
	logic [39:0] segBit;
	logic        pol;
	logic [2:0]  row;

	always_comb
	begin
		// second half of a frame inverts every level for dc balance
		pol = (phase_q >= nCom);
		row = pol ? 3'(phase_q - nCom) : phase_q[2:0];
		segEn = {4'h0, cfg.segmentPinEnable};
		segBit = 40'h00_0000_0000;
		for (int s = 0; s < slcd_pkg::NUM_SEG; s++)
			segBit[s] = pixMem_q[s][row];
		pins_d = '0;
		for (int p = 0; p < slcd_pkg::NUM_PINS; p++)
		begin
			if (enable_q)
			begin
				if (pinIsCom(p, cfg.commonCountSelect))
				begin
					pins_d.lcdOwned[p] = 1'b1;
					if (pinComIndex(p) == row)
						pins_d.level[p] = pol ? slcd_pkg::LVL_GND : slcd_pkg::LVL_VLCD;
					else
						pins_d.level[p] = pol ? slcd_pkg::LVL_V2 : slcd_pkg::LVL_V1;
					pins_d.outLatch[p] = pol;
				end
				else if (segEn[p])
				begin
					pins_d.lcdOwned[p] = 1'b1;
					if (segBit[p])
						pins_d.level[p] = pol ? slcd_pkg::LVL_VLCD : slcd_pkg::LVL_GND;
					else
						pins_d.level[p] = pol ? slcd_pkg::LVL_V1 : slcd_pkg::LVL_V2;
					pins_d.outLatch[p] = pol ^ segBit[p];
				end
				pins_d.biasSwitch[p] = pins_d.lcdOwned[p] & ~cfg.staticModeSelect;
			end
			else if (cfg.idleCommonDrive && pinIsCom(p, cfg.commonCountSelect))
			begin
				pins_d.lcdOwned[p] = 1'b1;
				pins_d.biasSwitch[p] = ~cfg.staticModeSelect;
				pins_d.level[p] = slcd_pkg::LVL_V1;
				pins_d.outLatch[p] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pins <= '0;
			biasGenOn <= 1'b0;
		end
		else
		begin
			pins <= pins_d;
			// bias ladder only runs in multiplexed mode
			biasGenOn <= ~cfg.staticModeSelect & (enable_q | cfg.idleCommonDrive);
		end
	end

endmodule : slcd_driver

// ===== dv/slcd_driver_sva.sv
// Purpose: port checks of the segment display driver
// Assumes: one clock, async active-high reset
// Notes:   pins lag the enable register by one cycle
`timescale 1ns/1ps
module slcd_driver_sva (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire slcd_pkg::slcd_cfg_t  cfg,
	input wire logic                 enableWrite,
	input wire logic                 irqAccept,
	input wire logic                 inStop,
	input wire logic                 displayEnableBit,
	input wire logic                 frameDoneFlag,
	input wire logic                 irqRequest,
	input wire logic                 wakeRequest,
	input wire logic                 biasGenOn,
	input wire slcd_pkg::slcd_pins_t pins
);
	// --------
	// checks
	// --------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [3:0] claim;
	assign claim = {cfg.commonCountSelect != 2'h0, cfg.commonCountSelect != 2'h0,
		cfg.commonCountSelect[1], cfg.commonCountSelect == 2'h3};
	AST_IRQ_LEVEL: assert property ($stable(cfg.frameIrqEnable)
		|-> irqRequest == (frameDoneFlag && cfg.frameIrqEnable)) else $error("irq level wrong");
	AST_ACCEPT_CLEAR: assert property (irqAccept && frameDoneFlag |=> !frameDoneFlag)
		else $error("flag kept after accept");
	AST_FLAG_STICKY: assert property (frameDoneFlag && !irqAccept |=> frameDoneFlag)
		else $error("flag dropped unasked");
	AST_STATIC_NOBIAS: assert property (cfg.staticModeSelect && $past(cfg.staticModeSelect)
		|-> pins.biasSwitch == '0 && !biasGenOn) else $error("bias on in static");
	AST_OFF_GPIO: assert property (!displayEnableBit && !$past(displayEnableBit)
		&& !cfg.idleCommonDrive && $stable(cfg) |-> pins.lcdOwned == '0) else $error("pin kept");
	AST_DED_COM: assert property (displayEnableBit && $past(displayEnableBit)
		|-> pins.lcdOwned[39:36] == 4'hF) else $error("dedicated common not owned");
	AST_SEG_OWN: assert property (displayEnableBit && $past(displayEnableBit) && $stable(cfg)
		|-> pins.lcdOwned[31:0] == cfg.segmentPinEnable[31:0]) else $error("segment owner wrong");
	AST_SHARED_COM: assert property (displayEnableBit && $past(displayEnableBit) && $stable(cfg)
		|-> pins.lcdOwned[35:32] == (cfg.segmentPinEnable[35:32] | claim))
		else $error("shared pin owner wrong");
	AST_SINGLE_END: assert property ($fell(displayEnableBit) && !$past(enableWrite)
		|-> frameDoneFlag && $past(cfg.singleFrameSelect)) else $error("enable cleared unasked");
	AST_RESTART: assert property ($rose(displayEnableBit) |-> (!$rose(frameDoneFlag)) [*8])
		else $error("frame ended right after enable");
	AST_WAKE_GATE: assert property ($stable(cfg) && $stable(inStop)
		|-> wakeRequest == (irqRequest && (!inStop || cfg.stopWakeEnable)))
		else $error("wake request gating wrong");
	AST_STATIC_COM_LATCH: assert property (displayEnableBit && $past(displayEnableBit)
		&& cfg.staticModeSelect && $stable(cfg)
		|-> pins.outLatch[39:36] == {4{pins.outLatch[36]}}) else $error("static common latch split");
	COV_STOP_WAKE: cover property (inStop && wakeRequest);
	COV_FRAME: cover property ($rose(frameDoneFlag));
	COV_SINGLE: cover property ($fell(displayEnableBit) && cfg.singleFrameSelect);
	COV_STATIC: cover property (cfg.staticModeSelect && displayEnableBit);
endmodule : slcd_driver_sva

bind slcd_driver slcd_driver_sva sva (.clk, .rst, .cfg, .enableWrite, .irqAccept, .inStop,
	.displayEnableBit, .frameDoneFlag, .irqRequest, .wakeRequest, .biasGenOn, .pins);

// ===== dv/slcd_panel.sv
// Purpose: glass model, notes which pixels of segment pin 0 saw full drive
// Assumes: pixel lights only when common and segment sit on opposite rails
// Notes:   clear restarts the record
`timescale 1ns/1ps
module slcd_panel (
	input wire logic                 clk,
	input wire logic                 clear,
	input wire slcd_pkg::slcd_pins_t pins,
	output logic [7:0]               lit
);
	function automatic int comPin(input int k);
		return (k < 4) ? 36 + k : 39 - k;
	endfunction : comPin
	always_ff @(posedge clk)
		for (int k = 0; k < 8; k++)
			if (clear)
				lit[k] <= 1'b0;
			else if (pins.lcdOwned[0] && pins.lcdOwned[comPin(k)] && pins.biasSwitch[0]
				&& {pins.level[comPin(k)], pins.level[0]} inside {4'h3, 4'hC})
				lit[k] <= 1'b1;
endmodule : slcd_panel

// ===== dv/segment_lcd_driver_test.sv
// Purpose: self-checking bench of the segment display driver
// Assumes: oscillator ticks are sped up to keep frames short
// Notes:   frame length is judged between the first two frames of a run
`timescale 1ns/1ps
module segment_lcd_driver_test;
	logic clk = 0, rst = 1, enableWrite = 0, enableValue = 0, rcTick = 0, xtalTick = 0;
	logic irqAccept = 0, inStop = 0, clearLit = 0, prevFlag = 0;
	slcd_pkg::slcd_cfg_t   cfg = '0;
	slcd_pkg::slcd_bufwr_t bufWrite = '0;
	slcd_pkg::slcd_pins_t  pins;
	logic displayEnableBit, frameDoneFlag, irqRequest, wakeRequest, biasGenOn;
	logic [7:0]  bufReadData, lit;
	logic [31:0] lfsr = 88177;
	int fails = 0, testsRun = 0, cyc = 0, lastRise = -1;
	int expQ[$];

	slcd_driver DUT (.clk, .rst, .cfg, .enableWrite, .enableValue, .bufWrite, .rcTick,
		.xtalTick, .irqAccept, .inStop, .displayEnableBit, .frameDoneFlag, .irqRequest,
		.wakeRequest, .biasGenOn, .bufReadData, .pins);
	slcd_panel panel (.clk, .clear(clearLit), .pins, .lit);

	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRand
	task automatic testDone;
		if (fails == 0 && testsRun > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : testDone
	task automatic check(input logic ok, input string msg);
		testsRun++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : check
	task automatic setEnable(input logic v);
		@(posedge clk);
		enableWrite <= 1'b1;
		enableValue <= v;
		@(posedge clk);
		enableWrite <= 1'b0;
		#1;
	endtask : setEnable
	task automatic writeBuf(input logic [5:0] p, input logic [7:0] d);
		@(posedge clk);
		bufWrite.pointerWrite <= 1'b1;
		bufWrite.bufferPointer <= p;
		@(posedge clk);
		bufWrite.pointerWrite <= 1'b0;
		bufWrite.dataWrite <= 1'b1;
		bufWrite.bufferDataPort <= d;
		@(posedge clk);
		bufWrite.dataWrite <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : writeBuf

	// --------
	// clock, oscillators, acceptor and frame monitor
	// --------
	initial forever #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc % 3 == 0) rcTick <= ~rcTick;
		if (cyc % 2 == 0) xtalTick <= ~xtalTick;
		irqAccept <= frameDoneFlag & ~irqAccept;
		if (frameDoneFlag === 1'b1 && !prevFlag)
		begin
			if (lastRise >= 0 && expQ.size() > 0)
				check(cyc - lastRise == expQ.pop_front(), "frame length");
			lastRise = cyc;
		end
		prevFlag = frameDoneFlag;
		if (cyc == 60000)
		begin
			fails++;
			testDone();
		end
	end

	initial
	begin
		slcd_pkg::slcd_cfg_t nc;
		logic [7:0] d;
		int n, len;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(pins === '0 && displayEnableBit === 1'b0, "reset state");
		writeBuf(6'h28, 8'hA5);
		check(bufReadData === 8'h00, "pointer past buffer");
		// one run per common count, also sweeping divider and source
		for (int c = 0; c < 4; c++)
		begin
			lfsr = nextRand(lfsr);
			d = lfsr[7:0];
			n = (c == 0) ? 4 : c + 5;
			len = 2 * n * (16 << c) * (c[0] ? 4 : 6);
			nc = '0;
			nc.commonCountSelect = c[1:0];
			nc.frameDividerSelect = c[1:0];
			nc.frameClockSourceSelect = c[0];
			nc.segmentPinEnable = {lfsr[31:0], lfsr[11:8]} | 36'h1;
			nc.frameIrqEnable = lfsr[12];
			@(posedge clk) cfg <= nc;
			writeBuf(6'h00, d);
			check(bufReadData === d, "buffer readback");
			@(posedge clk) clearLit <= 1'b1;
			@(posedge clk) clearLit <= 1'b0;
			lastRise = -1;
			expQ.push_back(len);
			setEnable(1'b1);
			for (int i = 0; i < 3 * len && expQ.size() > 0; i++) @(posedge clk);
			#1;
			check(expQ.size() == 0, "frames missing");
			check(lit === (d & 8'((16'h1 << n) - 16'h1)), "pixel drive");
			check(pins.lcdOwned[35:32] === (nc.segmentPinEnable[35:32]
				| 4'(4'hF << (8 - n))), "shared ownership");
			setEnable(1'b0);
			repeat (2) @(posedge clk);
			#1;
			check(pins.lcdOwned === '0, "pins released");
		end
		nc = '0;
		nc.staticModeSelect = 1'b1;
		nc.singleFrameSelect = 1'b1;
		nc.idleCommonDrive = 1'b1;
		nc.segmentPinEnable = 36'h1;
		@(posedge clk) cfg <= nc;
		setEnable(1'b1);
		for (int i = 0; i < 3000 && displayEnableBit !== 1'b0; i++) @(posedge clk);
		repeat (2) @(posedge clk);
		#1;
		check(displayEnableBit === 1'b0, "single frame end");
		check(pins.outLatch[39:36] === 4'hF, "static idle level");
		nc.staticModeSelect = 1'b0;
		@(posedge clk) cfg <= nc;
		repeat (2) @(posedge clk);
		#1;
		check(pins.level[36] === slcd_pkg::LVL_V1 && biasGenOn === 1'b1, "idle level");
		// stop mode: frozen without stop-wake, frames and wake with it
		nc = '0;
		nc.frameIrqEnable = 1'b1;
		nc.segmentPinEnable = 36'h1;
		@(posedge clk) cfg <= nc;
		inStop <= 1'b1;
		setEnable(1'b1);
		repeat (1000) @(posedge clk);
		#1;
		check(frameDoneFlag === 1'b0 && wakeRequest === 1'b0, "counting in stop");
		nc.stopWakeEnable = 1'b1;
		@(posedge clk) cfg <= nc;
		for (int i = 0; i < 2000 && frameDoneFlag !== 1'b1; i++) @(posedge clk);
		#1;
		check(wakeRequest === 1'b1 && irqRequest === 1'b1, "stop wake");
		setEnable(1'b0);
		inStop <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(pins.lcdOwned === '0, "pins released after stop");
		testDone();
	end
endmodule : segment_lcd_driver_test
